// File: rtl/umcp_top.sv
// Modem control pins, interrupt gating and character framing for one UART channel
`timescale 1ns/1ps
// Behaviour
// - Drive request-to-send low from control bit; auto flow needs it asserted first.
// - Sample clear-to-send; optionally hold transmitter while it is high.
// - Drive data-terminal-ready low from its software control bit.
// - Set-ready, carrier and ring inputs are status only, no datapath effect.
// - User bit one: user output low, interrupt enabled; else high, tri-stated.
// - Reset returns every register and every output to its default.
// - During reset transmit stays high and receive input is ignored.
// - Transmit frames start bit, data, two stop bits; receiver deframes to parallel.
// - Transmitter appends parity; receiver checks parity and flags errors.
// - Transmit idles high in standard mode and low in infrared mode.
module umcp_top
(
    input  wire logic                          clk_sys,
    input  wire logic                          rst_n,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          rx_in,
    output logic                               tx_out,
    input  wire logic                          clear_send_in_n,
    input  wire logic                          set_ready_in_n,
    input  wire logic                          carrier_detect_in_n,
    input  wire logic                          ring_indicate_in_n,
    output logic                               request_send_out_n,
    output logic                               terminal_ready_out_n,
    output logic                               user_output_n,
    output logic                               channel_irq_out,
    output logic                               channel_irq_oe
);
    import umcp_pkg::*;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [7:0]        irq_enable_reg;
    logic [7:0]        modem_control_reg;
    logic [7:0]        enhanced_feature_reg;
    logic [EV_W-1:0]   stat;
    logic [EV_W-1:0]   mask;
    logic [15:0]       div;
    logic [7:0]        rx_hold;
    logic [7:0]        tx_hold;
    logic              tx_pend;
    logic [3:0]        pins;

    wire acc     = psel && penable && pready;
    wire wr      = acc && pwrite;
    wire hit     = (paddr == REG_DATA) || (paddr == REG_IRQEN) || (paddr == REG_MODEM)
                || (paddr == REG_EFEAT) || (paddr == REG_PINS) || (paddr == REG_STAT)
                || (paddr == REG_MASK) || (paddr == REG_DIV);
    wire wr_data = wr && paddr == REG_DATA;
    wire wr_stat = wr && paddr == REG_STAT;

    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            REG_DATA:  rd_mux = {24'h00_0000, rx_hold};
            REG_IRQEN: rd_mux = {24'h00_0000, irq_enable_reg};
            REG_MODEM: rd_mux = {24'h00_0000, modem_control_reg};
            REG_EFEAT: rd_mux = {24'h00_0000, enhanced_feature_reg};
            REG_PINS:  rd_mux = {28'h000_0000, pins};
            REG_STAT:  rd_mux = {27'h000_0000, stat};
            REG_MASK:  rd_mux = {27'h000_0000, mask};
            REG_DIV:   rd_mux = {16'h0000, div};
            default:   rd_mux = 32'h0000_0000;
        endcase
    end

    // No wait state: pready rises in the first access cycle, so every access takes two edges
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (psel && !penable && !pwrite)
                prdata <= rd_mux;
        end
    end

    // Control registers clear under reset, except div which loads DIV_RESET
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_enable_reg       <= 8'h00;
            modem_control_reg    <= 8'h00;
            enhanced_feature_reg <= 8'h00;
            mask                 <= 5'h00;
            div                  <= DIV_RESET;
        end
        else if (wr)
        begin
            if (paddr == REG_IRQEN) irq_enable_reg       <= pwdata[7:0];
            if (paddr == REG_MODEM) modem_control_reg    <= pwdata[7:0];
            if (paddr == REG_EFEAT) enhanced_feature_reg <= pwdata[7:0];
            if (paddr == REG_MASK)  mask                 <= pwdata[EV_W-1:0];
            if (paddr == REG_DIV)   div                  <= (pwdata[15:0] == 16'h0000)
                                                            ? 16'h0001 : pwdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // Modem pins
    // ------------------------------------------------------------
    logic cts_q;
    wire  auto_cts = enhanced_feature_reg[EF_ACTS] && irq_enable_reg[IE_ACTS];
    wire  auto_rts = enhanced_feature_reg[EF_ARTS] && irq_enable_reg[IE_ARTS];
    wire  ir_mode  = modem_control_reg[MC_IR];
    wire  tx_hold_off = auto_cts && cts_q;
    logic rx_busy;
    // Auto request-send only deasserts an already asserted line while a char is coming in and one is waiting to be sent
    wire  next_rts_n = !(modem_control_reg[MC_RTS] && !(auto_rts && rx_busy && tx_pend));

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cts_q                <= 1'b1;
            pins                 <= 4'hF;
            request_send_out_n   <= 1'b1;
            terminal_ready_out_n <= 1'b1;
            user_output_n        <= 1'b1;
        end
        else
        begin
            cts_q                <= clear_send_in_n;
            pins                 <= {ring_indicate_in_n, carrier_detect_in_n,
                                     set_ready_in_n, clear_send_in_n};
            request_send_out_n   <= next_rts_n;
            terminal_ready_out_n <= !modem_control_reg[MC_DTR];
            user_output_n        <= !modem_control_reg[MC_OUT2];
        end
    end

    // ------------------------------------------------------------
    // Bit timing
    // ------------------------------------------------------------
    function automatic logic tick(input logic [15:0] cnt, input logic [15:0] per);
        tick = (cnt == per - 16'h0001);
    endfunction

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    umcp_state_e tx_st;
    logic [15:0] tx_cnt;
    logic [2:0]  tx_bit;
    logic [7:0]  tx_sh;
    logic        tx_par;
    logic        tx_ser;
    logic        tx_done;
    wire         tx_tick = tick(tx_cnt, div);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_st   <= UMCP_IDLE;
            tx_cnt  <= 16'h0000;
            tx_bit  <= 3'h0;
            tx_sh   <= 8'h00;
            tx_par  <= 1'b0;
            tx_ser  <= 1'b1;
            tx_done <= 1'b0;
            tx_pend <= 1'b0;
            tx_hold <= 8'h00;
        end
        else
        begin
            tx_done <= 1'b0;
            tx_cnt  <= (tx_st == UMCP_IDLE || tx_tick) ? 16'h0000 : tx_cnt + 16'h0001;
            if (wr_data)
            begin
                tx_hold <= pwdata[7:0];
                tx_pend <= 1'b1;
            end
            unique case (tx_st)
                UMCP_IDLE:
                    if (tx_pend && !tx_hold_off)
                    begin
                        tx_st   <= UMCP_START;
                        tx_sh   <= tx_hold;
                        tx_par  <= ~^tx_hold;
                        tx_pend <= wr_data;
                        tx_ser  <= 1'b0;
                    end
                UMCP_START:
                    if (tx_tick)
                    begin
                        tx_st  <= UMCP_DATA;
                        tx_bit <= 3'h0;
                        tx_ser <= tx_sh[0];
                        tx_sh  <= tx_sh >> 1;
                    end
                UMCP_DATA:
                    if (tx_tick)
                    begin
                        tx_bit <= tx_bit + 3'h1;
                        if (tx_bit == 3'h7)
                        begin
                            tx_st  <= UMCP_STOP;
                            tx_ser <= tx_par;
                        end
                        else
                        begin
                            tx_ser <= tx_sh[0];
                            tx_sh  <= tx_sh >> 1;
                        end
                    end
                UMCP_STOP:
                    if (tx_tick)
                    begin
                        // Phase 0 ends the parity bit, phases 1 and 2 are the stop periods
                        if (tx_bit != 3'h2)
                        begin
                            tx_ser <= 1'b1;
                            tx_bit <= tx_bit + 3'h1;
                        end
                        else
                        begin
                            tx_st   <= UMCP_IDLE;
                            tx_done <= 1'b1;
                        end
                    end
            endcase
        end
    end

    // Infrared mode inverts the line so the idle level reads low
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            tx_out <= 1'b1;
        else
            tx_out <= ir_mode ? !tx_ser : tx_ser;
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    umcp_state_e rx_st;
    logic [15:0] rx_cnt;
    logic [3:0]  rx_bit;
    logic [8:0]  rx_sh;
    logic        rx_s;
    logic        rx_ok;
    logic        rx_perr;
    logic        rx_ferr;
    wire         rx_tick = tick(rx_cnt, div);
    wire         rx_mid  = tick(rx_cnt, {1'b0, div[15:1]} + 16'h0001);
    wire         rx_line = ir_mode ? !rx_s : rx_s;

    assign rx_busy = (rx_st != UMCP_IDLE);

    // The input is ignored under reset since every stage here is held at its reset value
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_s    <= 1'b1;
            rx_st   <= UMCP_IDLE;
            rx_cnt  <= 16'h0000;
            rx_bit  <= 4'h0;
            rx_sh   <= 9'h000;
            rx_hold <= 8'h00;
            rx_ok   <= 1'b0;
            rx_perr <= 1'b0;
            rx_ferr <= 1'b0;
        end
        else
        begin
            rx_s    <= rx_in;
            rx_ok   <= 1'b0;
            rx_perr <= 1'b0;
            rx_ferr <= 1'b0;
            rx_cnt  <= (rx_st == UMCP_IDLE || rx_tick) ? 16'h0000 : rx_cnt + 16'h0001;
            unique case (rx_st)
                UMCP_IDLE:
                    if (!rx_line)
                        rx_st <= UMCP_START;
                UMCP_START:
                    if (rx_mid)
                    begin
                        // A glitch shorter than half a bit is not a start bit
                        rx_st  <= rx_line ? UMCP_IDLE : UMCP_DATA;
                        rx_bit <= 4'h0;
                    end
                UMCP_DATA:
                    if (rx_mid)
                    begin
                        rx_sh  <= {rx_line, rx_sh[8:1]};
                        rx_bit <= rx_bit + 4'h1;
                        if (rx_bit == 4'h8)
                            rx_st <= UMCP_STOP;
                    end
                UMCP_STOP:
                    if (rx_mid)
                    begin
                        rx_st   <= UMCP_IDLE;
                        rx_hold <= rx_sh[7:0];
                        rx_ok   <= 1'b1;
                        rx_perr <= (^rx_sh) != 1'b1;
                        rx_ferr <= !rx_line;
                    end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    wire [EV_W-1:0] ev = {cts_q != clear_send_in_n, rx_ferr, rx_perr, rx_ok, tx_done};
    // Set wins over a clear in the same cycle
    wire [EV_W-1:0] next_stat = (stat & ~(wr_stat ? pwdata[EV_W-1:0] : 5'h00)) | ev;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stat            <= 5'h00;
            channel_irq_out <= 1'b0;
            channel_irq_oe  <= 1'b0;
        end
        else
        begin
            stat            <= next_stat;
            channel_irq_out <= |(next_stat & mask);
            channel_irq_oe  <= modem_control_reg[MC_OUT2];
        end
    end

endmodule

// File: rtl/umcp_pkg.sv
// Package with register map, field positions and timing constants for the modem pin block
package umcp_pkg;

    // Register byte offsets
    localparam logic [7:0] REG_DATA   = 8'h00;  // Write: transmit char, read: received char
    localparam logic [7:0] REG_IRQEN  = 8'h04;  // Interrupt enable (auto flow bits too)
    localparam logic [7:0] REG_MODEM  = 8'h08;  // Modem control
    localparam logic [7:0] REG_EFEAT  = 8'h0C;  // Enhanced feature control
    localparam logic [7:0] REG_PINS   = 8'h10;  // Modem input status (read only)
    localparam logic [7:0] REG_STAT   = 8'h14;  // Sticky events, write one to clear
    localparam logic [7:0] REG_MASK   = 8'h18;  // Event mask
    localparam logic [7:0] REG_DIV    = 8'h1C;  // Bit period in clk_sys cycles

    // Modem control fields
    localparam int MC_DTR  = 0;
    localparam int MC_RTS  = 1;
    localparam int MC_OUT2 = 3;
    localparam int MC_IR   = 6;
    // Interrupt enable fields used by auto flow control
    localparam int IE_ARTS = 6;
    localparam int IE_ACTS = 7;
    // Enhanced feature fields
    localparam int EF_ARTS = 6;
    localparam int EF_ACTS = 7;

    // Event status fields
    localparam int EV_TXDONE = 0;
    localparam int EV_RXDONE = 1;
    localparam int EV_PARERR = 2;
    localparam int EV_FRMERR = 3;
    localparam int EV_CTSCHG = 4;
    localparam int EV_W      = 5;

    localparam int          DATA_W    = 8;
    localparam logic [15:0] DIV_RESET = 16'h0015;   // 40 MHz / 21 is about 1.9 Mbit/s

    // Reset pulse width and its count at 40 MHz
    localparam int CLK_MHZ      = 40;
    localparam int RST_MIN_NS   = 40;
    localparam int RST_MIN_CYC  = (RST_MIN_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0]
    {
        UMCP_IDLE  = 2'b00,
        UMCP_START = 2'b01,
        UMCP_DATA  = 2'b10,
        UMCP_STOP  = 2'b11
    } umcp_state_e;

endpackage

// File: verif/umcp_props.sv
// Port-level assertions for the modem pin block
`timescale 1ns/1ps
module umcp_props
(
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       tx_out,
    input wire logic       request_send_out_n,
    input wire logic       terminal_ready_out_n,
    input wire logic       user_output_n,
    input wire logic       channel_irq_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Completed write; pin registers may lag it by one stage
    wire wr_acc = psel && penable && pwrite && pready;

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence

    a_ready_pulse: assert property (s_setup |=> s_answer)
        else $error("pready did not pulse once after setup");
    a_ready_cause: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_unmapped: assert property (pready && (paddr > 8'h1C || paddr[1:0] != 2'b00) |-> pslverr)
        else $error("unmapped access not refused");
    a_reset_idle: assert property ($rose(rst_n) |-> tx_out && request_send_out_n &&
        terminal_ready_out_n && user_output_n && !channel_irq_oe)
        else $error("outputs not at defaults after reset");
    a_irq_oe_user: assert property (channel_irq_oe != user_output_n)
        else $error("interrupt enable and user output disagree");
    a_start_width: assert property ($fell(tx_out) |-> (!tx_out) [*8])
        else $error("start bit too short");
    a_dtr_by_write: assert property ($changed(terminal_ready_out_n) && $past(rst_n)
        |-> $past(wr_acc) || $past(wr_acc, 2))
        else $error("terminal ready moved without a write");
    a_user_by_write: assert property ($changed(user_output_n) && $past(rst_n)
        |-> $past(wr_acc) || $past(wr_acc, 2))
        else $error("user output moved without a write");
endmodule

bind umcp_top umcp_props i_umcp_props
(
    .clk_sys              (clk_sys),
    .rst_n                (rst_n),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pready               (pready),
    .pslverr              (pslverr),
    .tx_out               (tx_out),
    .request_send_out_n   (request_send_out_n),
    .terminal_ready_out_n (terminal_ready_out_n),
    .user_output_n        (user_output_n),
    .channel_irq_oe       (channel_irq_oe)
);

// File: verif/umcp_modem.sv
// Behavioural remote serial device facing the modem pin block
`timescale 1ns/1ps
module umcp_modem
(
    input  wire logic clk_sys,
    input  wire logic tx_out,
    output logic      rx_in,
    output logic      clear_send_in_n,
    output logic      set_ready_in_n,
    output logic      carrier_detect_in_n,
    output logic      ring_indicate_in_n
);
    import umcp_pkg::*;
    localparam int BIT = int'(DIV_RESET);

    initial
    begin
        rx_in = 1'b1;
        {ring_indicate_in_n, carrier_detect_in_n, set_ready_in_n, clear_send_in_n} = 4'hF;
    end

    task automatic pins(input logic [3:0] v);
        {ring_indicate_in_n, carrier_detect_in_n, set_ready_in_n, clear_send_in_n} <= v;
    endtask

    task automatic rx_level(input logic v);
        rx_in <= v;
    endtask

    // Odd parity; the error flags corrupt parity or stop on purpose
    task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
        logic [10:0] f;
        f = {~bad_stop, ~^d ^ bad_par, d, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            rx_in <= f[i];
            repeat (BIT) @(posedge clk_sys);
        end
        rx_in <= 1'b1;
    endtask

    // Samples mid-bit; returns unknowns if no start bit shows up
    task automatic rx_char(output logic [7:0] d, output logic p, output logic s);
        int n;
        n = 0;
        d = 8'hXX;
        p = 1'bx;
        s = 1'bx;
        while (tx_out !== 1'b0 && n < 3000)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (n < 3000)
        begin
            repeat (BIT / 2) @(posedge clk_sys);
            for (int i = 0; i < 10; i++)
            begin
                repeat (BIT) @(posedge clk_sys);
                if (i < 8)
                    d[i] = tx_out;
                else if (i == 8)
                    p = tx_out;
                else
                    s = tx_out;
            end
        end
    endtask
endmodule

// File: verif/tb.sv
// Self-checking bench for the modem pin block
`timescale 1ns/1ps
module tb;
    import umcp_pkg::*;
    localparam int BIT = int'(DIV_RESET);
    logic        clk_sys = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata, q;
    logic        pready, pslverr, tx_out, rx_in, se, p, s, hi;
    logic        clear_send_in_n, set_ready_in_n, carrier_detect_in_n, ring_indicate_in_n;
    logic        request_send_out_n, terminal_ready_out_n, user_output_n;
    logic        channel_irq_out, channel_irq_oe;
    logic [7:0]  d;
    int          num_errors = 0;
    int          num_checks = 0;

    always #12.5 clk_sys = ~clk_sys;

    umcp_top i_umcp_top (.*);
    umcp_modem i_umcp_modem
    (
        .clk_sys             (clk_sys),
        .tx_out              (tx_out),
        .rx_in               (rx_in),
        .clear_send_in_n     (clear_send_in_n),
        .set_ready_in_n      (set_ready_in_n),
        .carrier_detect_in_n (carrier_detect_in_n),
        .ring_indicate_in_n  (ring_indicate_in_n)
    );

    task automatic end_sim;
        if (num_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; called just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk(32'(n < 20), 32'h1);
        q  = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask

    task automatic t_reset;
        i_umcp_modem.rx_level(1'b0);
        repeat (10) @(posedge clk_sys);
        chk(32'(tx_out), 32'h1);
        i_umcp_modem.rx_level(1'b1);
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk(32'({request_send_out_n, terminal_ready_out_n, user_output_n, channel_irq_oe}), 32'hE);
        rd(REG_STAT, 32'hFFFFFFFF, 32'h0);
    endtask

    task automatic t_modem_out;
        int b[3] = '{MC_DTR, MC_RTS, MC_OUT2};
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, REG_MODEM, 32'h1 << b[i]);
            repeat (2) @(posedge clk_sys);
            chk(32'({request_send_out_n, terminal_ready_out_n, user_output_n, channel_irq_oe}),
                32'({b[i] != MC_RTS, b[i] != MC_DTR, b[i] != MC_OUT2, b[i] == MC_OUT2}));
        end
        apb(1'b1, REG_MODEM, 32'h0);
    endtask

    task automatic t_pins;
        logic [3:0] v[3] = '{4'h5, 4'hA, 4'h0};
        for (int i = 0; i < 3; i++)
        begin
            i_umcp_modem.pins(v[i]);
            repeat (4) @(posedge clk_sys);
            rd(REG_PINS, 32'hF, 32'(v[i]));
        end
    endtask

    // Status inputs stay asserted here: framing must not care
    task automatic t_tx;
        logic [7:0] v[2] = '{8'hA5, 8'h00};
        apb(1'b1, REG_STAT, 32'h1F);
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, REG_DATA, 32'(v[i]));
            i_umcp_modem.rx_char(d, p, s);
            chk(32'({d, p, s}), 32'({v[i], ~^v[i], 1'b1}));
            repeat (2 * BIT) @(posedge clk_sys);
        end
        chk(32'(channel_irq_out), 32'h0);
        apb(1'b1, REG_MASK, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk(32'(channel_irq_out), 32'h1);
        apb(1'b1, REG_STAT, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk(32'(channel_irq_out), 32'h0);
        apb(1'b1, REG_MASK, 32'h0);
    endtask

    task automatic t_rx;
        logic [7:0] v[3]  = '{8'h3C, 8'h5A, 8'h81};
        logic [3:0] st[3] = '{4'h2, 4'h6, 4'hA};
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, REG_STAT, 32'h1F);
            i_umcp_modem.send(v[i], i == 1, i == 2);
            repeat (4) @(posedge clk_sys);
            rd(REG_STAT, 32'hE, 32'(st[i]));
            rd(REG_DATA, 32'hFF, 32'(v[i]));
        end
    endtask

    task automatic t_cts;
        i_umcp_modem.pins(4'h1);
        apb(1'b1, REG_EFEAT, (32'h1 << EF_ACTS) | (32'h1 << EF_ARTS));
        apb(1'b1, REG_IRQEN, (32'h1 << IE_ACTS) | (32'h1 << IE_ARTS));
        apb(1'b1, REG_STAT, 32'h1F);
        apb(1'b1, REG_DATA, 32'h96);
        hi = 1'b1;
        repeat (3 * BIT)
        begin
            @(posedge clk_sys);
            hi &= tx_out;
        end
        chk(32'(hi), 32'h1);
        // A char held back keeps request-send off while one comes in
        apb(1'b1, REG_MODEM, 32'h1 << MC_RTS);
        repeat (2) @(posedge clk_sys);
        chk(32'(request_send_out_n), 32'h0);
        fork
            i_umcp_modem.send(8'h11, 1'b0, 1'b0);
            begin
                repeat (5 * BIT) @(posedge clk_sys);
                chk(32'(request_send_out_n), 32'h1);
            end
        join
        repeat (2) @(posedge clk_sys);
        chk(32'(request_send_out_n), 32'h0);
        i_umcp_modem.pins(4'h0);
        i_umcp_modem.rx_char(d, p, s);
        chk(32'(d), 32'h96);
        repeat (2 * BIT) @(posedge clk_sys);
        rd(REG_STAT, 32'h10, 32'h10);
        apb(1'b1, REG_EFEAT, 32'h0);
        apb(1'b1, REG_IRQEN, 32'h0);
    endtask

    task automatic t_misc;
        apb(1'b1, REG_MODEM, 32'h1 << MC_IR);
        // Idle low must outlast the start-bit width check
        repeat (8) @(posedge clk_sys);
        chk(32'(tx_out), 32'h0);
        apb(1'b1, REG_MODEM, 32'h0);
        repeat (3) @(posedge clk_sys);
        chk(32'(tx_out), 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        chk({q[30:0], se}, 32'h1);
        apb(1'b1, REG_MODEM, 32'h0B);
        apb(1'b1, REG_MASK, 32'h1F);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(32'({request_send_out_n, terminal_ready_out_n, user_output_n, channel_irq_oe, tx_out}),
            32'h1D);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd(REG_MODEM, 32'hFF, 32'h0);
        rd(REG_MASK, 32'h1F, 32'h0);
    endtask

    initial
    begin
        t_reset();
        t_modem_out();
        t_pins();
        t_tx();
        t_rx();
        t_cts();
        t_misc();
        end_sim();
    end

    // Whole run needs well under 10000 cycles
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        num_errors++;
        end_sim();
    end
endmodule
